// [oprb_regs.svh]
// Register map, field layout and reset values of the output pin remap bank
`ifndef OPRB_REGS_SVH
`define OPRB_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OPRB_OUTPUT_MAP_PINS_14_15 12'h000
`define OPRB_OUTPUT_MAP_PINS_16_17 12'h004
`define OPRB_OUTPUT_MAP_PINS_18_19 12'h008
`define OPRB_OUTPUT_MAP_PINS_20_21 12'h00C
`define OPRB_OUTPUT_MAP_PINS_22_23 12'h010
`define OPRB_OUTPUT_MAP_PINS_24_25 12'h014
`define OPRB_OUTPUT_MAP_PINS_26_27 12'h018
`define OPRB_OUTPUT_MAP_PINS_28_29 12'h01C
`define OPRB_OUTPUT_MAP_PINS_30_31 12'h020

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define OPRB_ODD_LSB 8
`define OPRB_EVEN_LSB 0
`define OPRB_SEL_W 6
`define OPRB_FIRST_PIN 14
`define OPRB_NUM_REGS 9
`define OPRB_SEL_RESET 6'h00

// ------------------------------------------------------------
// Package variants and pins they lack
// ------------------------------------------------------------
`define OPRB_PKG_SMALL 2'h0
`define OPRB_PKG_MIDDLE 2'h1
`define OPRB_PKG_LARGE 2'h2
`define OPRB_PIN_GONE_SMALL_A 15
`define OPRB_PIN_GONE_SMALL_B 30
`define OPRB_PIN_GONE_MIDDLE 31

`endif

// [oprb_pkg.sv]
// Types shared by the output pin remap bank
package oprb_pkg;
  typedef logic [5:0] oprb_sel_t;
  typedef enum logic [1:0] {
    OPRB_SMALL,
    OPRB_MIDDLE,
    OPRB_LARGE
  } oprb_pkg_e;
endpackage

// [oprb_pin_drive.sv]
// One pin's output multiplexer over the peripheral output functions
module oprb_pin_drive #(
  parameter int NUM_FUNCS = 64
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire oprb_pkg::oprb_sel_t sel, // Function number for this pin
  input wire logic [NUM_FUNCS-1:0] func_out, // Peripheral output levels
  output logic pin_out, // Level driven to the pin
  output logic pin_oe // Pin driven by a peripheral
);
  import oprb_pkg::*;

  logic pin_out_nxt;
  logic pin_oe_nxt;
  logic pin_out_r;
  logic pin_oe_r;

  // Selector n picks function n; zero leaves the pin to its port latch
  always_comb begin
    pin_oe_nxt = 1'b0;
    pin_out_nxt = 1'b0;
    if (sel != '0 && int'(sel) < NUM_FUNCS) begin
      pin_oe_nxt = 1'b1;
      pin_out_nxt = func_out[sel];
    end
  end

  // Registered to keep the top outputs straight from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
endmodule

// [oprb_bank.sv]
// APB register bank routing peripheral outputs onto remappable pins 14 to 31
//
// Added by the designer: the address map and the APB register port.
`include "oprb_regs.svh"

module oprb_bank #(
  parameter oprb_pkg::oprb_pkg_e PKG_VARIANT = oprb_pkg::OPRB_LARGE, // Package variant
  parameter int NUM_FUNCS = 64 // Peripheral output functions
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [NUM_FUNCS-1:0] func_out, // Peripheral output levels
  output logic [17:0] pin_out, // Pins 14..31 output level
  output logic [17:0] pin_oe // Pins 14..31 driven by a function
);
  import oprb_pkg::*;

  localparam int NPINS = 2 * `OPRB_NUM_REGS;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Whether a pin's selector exists in the chosen package
  function automatic logic pin_exists(input int pin);
    logic ok;
    ok = 1'b1;
    if (PKG_VARIANT == OPRB_SMALL &&
        (pin == `OPRB_PIN_GONE_SMALL_A || pin == `OPRB_PIN_GONE_SMALL_B)) begin
      ok = 1'b0;
    end
    if (PKG_VARIANT != OPRB_LARGE && pin == `OPRB_PIN_GONE_MIDDLE) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Register index for a byte address, or -1 when unmapped
  function automatic int reg_index(input logic [11:0] addr);
    int idx;
    idx = -1;
    if (addr == `OPRB_OUTPUT_MAP_PINS_14_15) begin
      idx = 0;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_16_17) begin
      idx = 1;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_18_19) begin
      idx = 2;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_20_21) begin
      idx = 3;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_22_23) begin
      idx = 4;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_24_25) begin
      idx = 5;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_26_27) begin
      idx = 6;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_28_29) begin
      idx = 7;
    end else if (addr == `OPRB_OUTPUT_MAP_PINS_30_31) begin
      idx = 8;
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // Selector storage
  // ------------------------------------------------------------
  oprb_sel_t sel_r [NPINS];
  oprb_sel_t sel_nxt [NPINS];
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  int idx;

  // No wait state: setup, then access with pready already high, so every access takes two cycles
  always_comb begin
    idx = reg_index(paddr);
    sel_nxt = sel_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pready_nxt = 1'b1;
      pslverr_nxt = (idx < 0) || (paddr[1:0] != 2'b00);
      prdata_nxt = 32'h0000_0000;
      if (!pwrite && idx >= 0) begin
        // Unimplemented and absent fields read as zero
        prdata_nxt[`OPRB_EVEN_LSB +: `OPRB_SEL_W] = sel_r[2*idx];
        prdata_nxt[`OPRB_ODD_LSB +: `OPRB_SEL_W] = sel_r[2*idx+1];
      end
    end
    // Writes land in the access phase, the edge where pready is sampled
    if (psel && penable && pready_r && pwrite && !pslverr_r) begin
      idx = reg_index(paddr);
      if (pstrb[0] && pin_exists(`OPRB_FIRST_PIN + 2*idx)) begin
        sel_nxt[2*idx] = pwdata[`OPRB_EVEN_LSB +: `OPRB_SEL_W];
      end
      if (pstrb[1] && pin_exists(`OPRB_FIRST_PIN + 2*idx + 1)) begin
        sel_nxt[2*idx+1] = pwdata[`OPRB_ODD_LSB +: `OPRB_SEL_W];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NPINS; i++) begin
        sel_r[i] <= `OPRB_SEL_RESET;
      end
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ------------------------------------------------------------
  // Pin multiplexers
  // ------------------------------------------------------------
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    oprb_pin_drive #(
      .NUM_FUNCS(NUM_FUNCS)
    ) u_drive (
      .clk(clk),
      .rst_b(rst_b),
      .sel(sel_r[p]),
      .func_out(func_out),
      .pin_out(pin_out[p]),
      .pin_oe(pin_oe[p])
    );
  end
endmodule

// [oprb_asserts.sv]
// Port checker for the output pin remap bank
module oprb_asserts import oprb_pkg::*; #(
  parameter oprb_pkg_e PKG_VARIANT = OPRB_LARGE
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Data
  input wire logic [17:0] pin_oe // Enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_pad_bits_zero: assert property (pready |-> prdata[31:14] == 0 && prdata[7:6] == 0)
    else $error("pad bits set");
  a_gone_pins: assert property (PKG_VARIANT == OPRB_SMALL |-> !pin_oe[1] && !pin_oe[16])
    else $error("absent pin on");
  a_top_pin_idle: assert property (PKG_VARIANT != OPRB_LARGE |-> !pin_oe[17])
    else $error("pin 31 on");
  a_reset_clear: assert property ($rose(rst_b) |-> pin_oe == 0 && !pready)
    else $error("not clear");
  a_oe_after_write: assert property (!$stable(pin_oe) |-> $past(pwrite && pready, 2))
    else $error("enable moved");
endmodule

// [oprb_func_model.sv]
// Peripheral output functions seen by the remap bank
module oprb_func_model (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  output logic [63:0] func_out // Levels
);
  // Moves every cycle so a stale or wrong pick shows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) func_out <= 64'h0123_4567_89AB_CDEF;
    else func_out <= {func_out[62:0], ~func_out[63]};
  end
endmodule

// [tb_oprb_bank.sv]
// Bench for the output pin remap bank in its smallest package
module tb_oprb_bank import oprb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 0, prdata, d;
  logic [63:0] func_out, last_f;
  logic [17:0] pin_out, pin_oe;
  logic [33:0] expq[$], e;
  oprb_sel_t sel[18];
  int bad_count = 0, samples_checked = 0;
  always #50 clk = ~clk;
  always @(posedge clk) last_f = func_out;
  oprb_bank #(.PKG_VARIANT(OPRB_SMALL)) dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .func_out, .pin_out, .pin_oe);
  oprb_func_model u_func (.clk, .rst_b, .func_out);
  task automatic chk_bus(input string n, input logic [31:0] x, g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [31:0] x, g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(logic [11:0] a, logic w, logic [31:0] wd, logic [33:0] x,
                     logic [3:0] s = 4'hF);
    expq.push_back(x);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) if (pready === 1'b1) begin
    e = expq.pop_front();
    chk_bus("pslverr", 32'(e[32]), 32'(pslverr));
    if (e[33]) chk_bus("prdata", e[31:0], prdata);
  end
  initial begin
    void'($urandom(32));
    repeat (16) @(posedge clk);
    rst_b <= 1;
    for (int i = 0; i < 9; i++) apb(12'(4 * i), 0, 0, 34'h2_0000_0000);
    apb(12'h024, 0, 0, 34'h3_0000_0000);
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      sel[2 * i] = i == 8 ? 6'h00 : d[5:0];
      sel[2 * i + 1] = i % 8 == 0 ? 6'h00 : d[13:8];
      apb(12'(4 * i), 1, d, 34'h0);
      apb(12'(4 * i), 0, 0, {20'h8_0000, sel[2 * i + 1], 2'h0, sel[2 * i]});
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int k = 0; k < 18; k++) begin
      chk_pin("pin_oe", 32'(sel[k] != 0), 32'(pin_oe[k]));
      if (sel[k] != 0) chk_pin("pin_out", 32'(last_f[sel[k]]), 32'(pin_out[k]));
    end
    // Lane 0 strobe only: the odd field must keep its value
    d = $urandom;
    sel[2] = d[5:0];
    apb(12'h004, 1, d, 34'h0, 4'h1);
    apb(12'h004, 0, 0, {20'h8_0000, sel[3], 2'h0, sel[2]});
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    apb(12'h004, 0, 0, 34'h2_0000_0000);
    repeat (2) @(posedge clk);
    test_done();
  end
  initial begin
    #1_000_000;
    bad_count++;
    test_done();
  end
endmodule
bind oprb_bank oprb_asserts #(.PKG_VARIANT(PKG_VARIANT)) u_chk (.clk, .rst_b, .psel, .penable,
  .pwrite, .pready, .prdata, .pin_oe);
